/* File: src/seq_pkg.sv */
package seq_pkg;
  // time figures in their own units, counts derived at 50 MHz
  localparam int CLK_MHZ     = 50;
  localparam int WAIT_US     = 400;
  localparam int TOTAL_US    = 1200;
  localparam int UV_EN_US    = 2400;
  localparam int PG_DEB_US   = 63;
  localparam int UV_DLY_US   = 16;
  localparam int OV_FILT_NS  = 1500;
  localparam int MIN_OFF_NS  = 450;
  localparam int WAIT_CYC    = WAIT_US * CLK_MHZ;
  localparam int RAMP_CYC    = (TOTAL_US - WAIT_US) * CLK_MHZ;
  localparam int UV_EN_CYC   = UV_EN_US * CLK_MHZ;
  localparam int PG_DEB_CYC  = PG_DEB_US * CLK_MHZ;
  localparam int UV_DLY_CYC  = UV_DLY_US * CLK_MHZ;
  // least times round up to whole cycles
  localparam int OV_FILT_CYC = (OV_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int RAMP_STEPS  = 256;
  localparam int TW          = 17;
  localparam int RW          = 8;

  // register map, byte addresses
  localparam logic [3:0]  CTRL_OFS   = 4'h0;
  localparam logic [3:0]  ONTIME_OFS = 4'h4;
  localparam logic [3:0]  STATUS_OFS = 4'h8;
  localparam logic        NO_DIS_RST = 1'b0;
  localparam logic [15:0] ONTIME_RST = 16'h1319;
  localparam int NO_DIS_BIT = 0;
  localparam int ON500_LSB  = 0;
  localparam int ON670_LSB  = 8;
  localparam int ST_LSB     = 0;
  localparam int UV_BIT     = 3;
  localparam int OV_BIT     = 4;
  localparam int PG_BIT     = 5;
  localparam int MODE_LSB   = 6;
  localparam int SKIP_BIT   = 8;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_WAIT  = 3'b001,
    ST_RAMP  = 3'b010,
    ST_RUN   = 3'b011,
    ST_FAULT = 3'b100,
    ST_HOT   = 3'b101
  } seq_state_e;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_ON   = 2'b01,
    SW_OFF  = 2'b10
  } sw_phase_e;

  // codes 1 and 2 switch at 670 kHz, 0 and 3 at 500 kHz
  function automatic logic mode_fast(input logic [1:0] m);
    return (m == 2'h1) || (m == 2'h2);
  endfunction

  // codes 0 and 1 discharge through the termination regulator
  function automatic logic mode_tracks(input logic [1:0] m);
    return m <= 2'h1;
  endfunction
endpackage

/* File: src/hold_timer.sv */
`timescale 1ns/1ps
// done rises after run has stood for limit cycles, drops with run
module hold_timer (
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  input  wire logic                    run,
  input  wire logic [seq_pkg::TW-1:0]  limit,
  output logic                         done
);
  logic [seq_pkg::TW-1:0] count_reg;

  // saturating count, so a held condition never wraps
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
      done      <= 1'b0;
    end else if (!run) begin
      count_reg <= '0;
      done      <= 1'b0;
    end else begin
      if (count_reg < limit) begin
        count_reg <= count_reg + 1'b1;
      end
      done <= (count_reg >= limit - 1'b1);
    end
  end
endmodule

/* File: src/ramp_ctr.sv */
`timescale 1ns/1ps
// digital soft-start reference, one step per enable pulse
module ramp_ctr (
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  input  wire logic                    clear,
  input  wire logic                    up,
  input  wire logic                    step,
  output logic [seq_pkg::RW-1:0]       code
);
  // saturates at both ends; down-count is the soft-stop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      code <= '0;
    end else if (clear) begin
      code <= '0;
    end else if (step && up && code != '1) begin
      code <= code + 1'b1;
    end else if (step && !up && code != '0) begin
      code <= code - 1'b1;
    end
  end
endmodule

/* File: src/ddr_rail_sequencer_protection.sv */
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module ddr_rail_sequencer_protection #(
  parameter int WAIT_CYC  = seq_pkg::WAIT_CYC,
  parameter int RAMP_CYC  = seq_pkg::RAMP_CYC,
  parameter int UV_EN_CYC = seq_pkg::UV_EN_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 sleep_ctl_in,
  input  wire logic                 suspend_ctl_in,
  input  wire logic                 supply_ok_in,
  input  wire logic                 overtemp_in,
  input  wire logic [1:0]           mode_in,
  input  wire logic [7:0]           rail_code_in,
  input  wire logic                 pg_cmp_in,
  input  wire logic                 ov_cmp_in,
  input  wire logic                 uv_cmp_in,
  input  wire logic                 dis_cmp_in,
  input  wire logic                 err_cmp_in,
  input  wire logic                 valley_over_limit_in,
  input  wire logic                 zero_cross_in,
  output logic                      high_drive_out,
  output logic                      low_drive_out,
  output logic                      main_rail_en,
  output logic [7:0]                main_ref_code,
  output logic                      term_rail_en,
  output logic                      term_rail_hiz,
  output logic                      term_ref_en,
  output logic [7:0]                term_ref_code,
  output logic                      track_dis_out,
  output logic                      nontrack_dis_out,
  output logic                      power_good_out,
  output logic                      power_good_oe,
  output logic                      light_load_pulse_skip,
  output logic                      freq_670_out
);
  localparam int STEP_CYC = (RAMP_CYC / seq_pkg::RAMP_STEPS > 0) ?
                            RAMP_CYC / seq_pkg::RAMP_STEPS : 1;
  localparam logic [16:0] PG_N = 17'(seq_pkg::PG_DEB_CYC);

  seq_pkg::seq_state_e    st_reg;
  seq_pkg::seq_state_e    st_next;
  seq_pkg::sw_phase_e     sw_reg;
  seq_pkg::sw_phase_e     sw_next;
  logic                   sup_ok_reg;
  logic [1:0]             mode_reg;
  logic                   reached_reg;
  logic                   pg_seen_reg;
  logic                   uv_lat_reg;
  logic                   ov_lat_reg;
  logic                   no_dis_reg;
  logic [15:0]            ontime_reg;
  logic [16:0]            step_cnt_reg;
  logic                   step_reg;
  logic [31:0]            rd_word;
  logic                   wait_done;
  logic                   uv_en_done;
  logic                   pg_done;
  logic                   uv_done;
  logic                   ov_done;
  logic                   on_done;
  logic                   off_done;
  logic [7:0]             main_code;
  logic [7:0]             term_code;
  logic [7:0]             on_cyc;
  logic                   on_st;
  logic                   sw_allowed;
  logic                   sw_run;
  logic                   fire;
  logic                   pg_run;
  logic                   dis_on;
  logic                   trk;

  // supply-ok is ignored unless one sleep input is high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) sup_ok_reg <= 1'b0;
    else        sup_ok_reg <= (sleep_ctl_in | suspend_ctl_in) &
                              supply_ok_in;
  end

  assign on_st = (st_reg == seq_pkg::ST_RAMP) || (st_reg == seq_pkg::ST_RUN);

  // sequence; supply loss beats faults, faults beat control inputs
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      seq_pkg::ST_OFF:   if (suspend_ctl_in) begin
        st_next = seq_pkg::ST_WAIT;
      end
      seq_pkg::ST_WAIT:  if (wait_done) st_next = seq_pkg::ST_RAMP;
      seq_pkg::ST_RAMP:  if (main_code == '1) st_next = seq_pkg::ST_RUN;
      seq_pkg::ST_RUN,
      seq_pkg::ST_FAULT: st_next = st_reg;
      seq_pkg::ST_HOT:   if (!overtemp_in) begin
        st_next = seq_pkg::ST_WAIT;
      end
      default:           st_next = seq_pkg::ST_OFF;
    endcase
    if (!sup_ok_reg) st_next = seq_pkg::ST_OFF;
    else if (uv_lat_reg || ov_lat_reg) st_next = seq_pkg::ST_FAULT;
    else if (!suspend_ctl_in) st_next = seq_pkg::ST_OFF;
    else if (overtemp_in) st_next = seq_pkg::ST_HOT;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) st_reg <= seq_pkg::ST_OFF;
    else        st_reg <= st_next;
  end

  // mode is sampled on entry to the wait and frozen for the whole run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= 2'h0;
    end else if (st_next == seq_pkg::ST_WAIT &&
                 st_reg != seq_pkg::ST_WAIT) begin
      mode_reg <= mode_in;
    end
  end

  hold_timer u_wait (
    .clock (clock),
    .rst_b (rst_b),
    .run   (st_reg == seq_pkg::ST_WAIT),
    .limit (17'(WAIT_CYC)),
    .done  (wait_done)
  );

  // step divider: ramp length plus wait gives the fixed start time
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      step_cnt_reg <= '0;
      step_reg     <= 1'b0;
    end else if (!on_st && st_reg != seq_pkg::ST_FAULT) begin
      step_cnt_reg <= '0;
      step_reg     <= 1'b0;
    end else if (step_cnt_reg >= 17'(STEP_CYC - 1)) begin
      step_cnt_reg <= '0;
      step_reg     <= 1'b1;
    end else begin
      step_cnt_reg <= step_cnt_reg + 1'b1;
      step_reg     <= 1'b0;
    end
  end

  // main ramp counts down in fault for the soft-stop
  ramp_ctr u_main_ramp (
    .clock (clock),
    .rst_b (rst_b),
    .clear (!on_st && st_reg != seq_pkg::ST_FAULT),
    .up    (st_reg != seq_pkg::ST_FAULT),
    .step  (step_reg && st_reg != seq_pkg::ST_RUN),
    .code  (main_code)
  );

  // termination has its own counter, started only in full-on
  ramp_ctr u_term_ramp (
    .clock (clock),
    .rst_b (rst_b),
    .clear (!(on_st && sleep_ctl_in)),
    .up    (1'b1),
    .step  (step_reg),
    .code  (term_code)
  );

  // pre-biased output: no switching until the ramp catches up
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) reached_reg <= 1'b0;
    else        reached_reg <= (st_reg == seq_pkg::ST_RAMP) &&
                               (reached_reg ||
                                main_code >= rail_code_in);
  end

  assign sw_allowed = ((st_reg == seq_pkg::ST_RAMP) && reached_reg) ||
                      (st_reg == seq_pkg::ST_RUN);

  // power-good: debounced rise, but overvoltage kills it next edge
  assign pg_run = on_st && pg_cmp_in && !ov_cmp_in && !uv_lat_reg &&
                  !ov_lat_reg;

  hold_timer u_pg (
    .clock (clock),
    .rst_b (rst_b),
    .run   (pg_run),
    .limit (17'(seq_pkg::PG_DEB_CYC)),
    .done  (pg_done)
  );

  // only the main rail drives power-good
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_good_out <= 1'b0;
      power_good_oe  <= 1'b1;
      pg_seen_reg    <= 1'b0;
    end else begin
      power_good_out <= pg_done && pg_run;
      power_good_oe  <= !(pg_done && pg_run);
      pg_seen_reg    <= on_st && (pg_seen_reg || power_good_out);
    end
  end

  // undervoltage armed only after switching time and first good
  hold_timer u_uv_en (
    .clock (clock),
    .rst_b (rst_b),
    .run   (sw_allowed),
    .limit (17'(UV_EN_CYC)),
    .done  (uv_en_done)
  );

  hold_timer u_uv (
    .clock (clock),
    .rst_b (rst_b),
    .run   (on_st && uv_en_done && pg_seen_reg && uv_cmp_in),
    .limit (17'(seq_pkg::UV_DLY_CYC)),
    .done  (uv_done)
  );

  // overvoltage stays live through soft-start
  hold_timer u_ov (
    .clock (clock),
    .rst_b (rst_b),
    .run   (on_st && ov_cmp_in),
    .limit (17'(seq_pkg::OV_FILT_CYC)),
    .done  (ov_done)
  );

  // latches: a trip in the clearing cycle still sets
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      uv_lat_reg <= 1'b0;
      ov_lat_reg <= 1'b0;
    end else begin
      uv_lat_reg <= uv_done || (uv_lat_reg && sup_ok_reg);
      ov_lat_reg <= ov_done || (ov_lat_reg && sup_ok_reg);
    end
  end

  // switching cycle: on-time, minimum off-time, then wait for demand
  assign sw_run = sw_allowed && !uv_lat_reg && !ov_lat_reg && !ov_done;
  assign fire   = sw_run && err_cmp_in && !valley_over_limit_in;
  assign on_cyc = seq_pkg::mode_fast(mode_reg) ?
                  ontime_reg[seq_pkg::ON670_LSB +: 8] :
                  ontime_reg[seq_pkg::ON500_LSB +: 8];

  always_comb begin
    sw_next = sw_reg;
    unique case (sw_reg)
      seq_pkg::SW_IDLE: if (fire) sw_next = seq_pkg::SW_ON;
      seq_pkg::SW_ON:   if (on_done) sw_next = seq_pkg::SW_OFF;
      seq_pkg::SW_OFF:  if (off_done) begin
        sw_next = fire ? seq_pkg::SW_ON : seq_pkg::SW_IDLE;
      end
      default:          sw_next = seq_pkg::SW_IDLE;
    endcase
    if (!sw_run) sw_next = seq_pkg::SW_IDLE;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) sw_reg <= seq_pkg::SW_IDLE;
    else        sw_reg <= sw_next;
  end

  hold_timer u_on (
    .clock (clock),
    .rst_b (rst_b),
    .run   (sw_reg == seq_pkg::SW_ON),
    .limit ((on_cyc == 8'h00) ? 17'h0_0001 : {9'h000, on_cyc}),
    .done  (on_done)
  );

  hold_timer u_off (
    .clock (clock),
    .rst_b (rst_b),
    .run   (sw_reg == seq_pkg::SW_OFF),
    .limit (17'(seq_pkg::MIN_OFF_CYC)),
    .done  (off_done)
  );

  // gate drive; idle at zero cross lets frequency fall at light load
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      high_drive_out        <= 1'b0;
      low_drive_out         <= 1'b0;
      light_load_pulse_skip <= 1'b0;
    end else begin
      high_drive_out <= (sw_next == seq_pkg::SW_ON);
      low_drive_out  <= ov_done || ov_lat_reg ||
                        (sw_run && sw_next != seq_pkg::SW_ON &&
                         !(sw_next == seq_pkg::SW_IDLE && zero_cross_in));
      light_load_pulse_skip <= sw_run && zero_cross_in &&
                               (sw_next == seq_pkg::SW_IDLE);
    end
  end

  // rail enables from the two sleep inputs
  assign dis_on = !sleep_ctl_in && !suspend_ctl_in && supply_ok_in &&
                  !no_dis_reg;
  assign trk    = seq_pkg::mode_tracks(mode_reg);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      main_rail_en     <= 1'b0;
      term_rail_en     <= 1'b0;
      term_rail_hiz    <= 1'b0;
      term_ref_en      <= 1'b0;
      main_ref_code    <= 8'h00;
      term_ref_code    <= 8'h00;
      track_dis_out    <= 1'b0;
      nontrack_dis_out <= 1'b0;
      freq_670_out     <= 1'b0;
    end else begin
      main_rail_en     <= on_st;
      term_rail_en     <= on_st && sleep_ctl_in;
      term_rail_hiz    <= on_st && !sleep_ctl_in;
      term_ref_en      <= on_st;
      main_ref_code    <= main_code;
      term_ref_code    <= term_code;
      track_dis_out    <= dis_on && trk && !dis_cmp_in;
      nontrack_dis_out <= dis_on && (!trk || dis_cmp_in);
      freq_670_out     <= seq_pkg::mode_fast(mode_reg);
    end
  end

  // slave answers one cycle after it sees the request
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) avs_waitrequest <= 1'b1;
    else        avs_waitrequest <= !((avs_read || avs_write) &&
                                     avs_waitrequest);
  end

  // writes land on the edge the master sees waitrequest low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      no_dis_reg <= seq_pkg::NO_DIS_RST;
      ontime_reg <= seq_pkg::ONTIME_RST;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == seq_pkg::CTRL_OFS && avs_byteenable[0]) begin
        no_dis_reg <= avs_writedata[seq_pkg::NO_DIS_BIT];
      end
      if (avs_address == seq_pkg::ONTIME_OFS) begin
        if (avs_byteenable[0]) ontime_reg[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1]) ontime_reg[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (avs_address)
      seq_pkg::CTRL_OFS:   rd_word[seq_pkg::NO_DIS_BIT] = no_dis_reg;
      seq_pkg::ONTIME_OFS: rd_word[15:0] = ontime_reg;
      seq_pkg::STATUS_OFS: begin
        rd_word[seq_pkg::ST_LSB +: 3]   = st_reg;
        rd_word[seq_pkg::UV_BIT]        = uv_lat_reg;
        rd_word[seq_pkg::OV_BIT]        = ov_lat_reg;
        rd_word[seq_pkg::PG_BIT]        = power_good_out;
        rd_word[seq_pkg::MODE_LSB +: 2] = mode_reg;
        rd_word[seq_pkg::SKIP_BIT]      = light_load_pulse_skip;
      end
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_waitrequest) avs_readdata <= rd_word;
  end

  // checks
  logic [16:0] pg_cnt_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) pg_cnt_reg <= '0;
    else if (!pg_run) pg_cnt_reg <= '0;
    else if (pg_cnt_reg != '1) pg_cnt_reg <= pg_cnt_reg + 1'b1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_pg_off_state: assert property (st_reg == seq_pkg::ST_OFF |=>
    !power_good_out && power_good_oe) else $error("pg high in shutdown");
  a_pg_ov_drop: assert property (ov_cmp_in |=> !power_good_out)
    else $error("pg not dropped on overvoltage");
  a_pg_debounce: assert property ($rose(power_good_out) |->
    pg_cnt_reg >= PG_N) else $error("pg released before debounce");
  a_ov_clamp: assert property (ov_lat_reg |=>
    low_drive_out && !high_drive_out) else $error("ov latch not clamping");
  a_uv_drivers_off: assert property (uv_lat_reg && !ov_lat_reg |=>
    !high_drive_out && !low_drive_out) else $error("uv latch drives gate");
  a_uv_latch_hold: assert property (uv_lat_reg && sup_ok_reg |=>
    uv_lat_reg) else $error("uv latch cleared without supply toggle");
  a_limit_block: assert property (sw_reg == seq_pkg::SW_IDLE &&
    valley_over_limit_in |=> sw_reg != seq_pkg::SW_ON)
    else $error("cycle started above current limit");
  a_min_off_time: assert property (
    $rose(sw_reg == seq_pkg::SW_OFF) |-> (sw_reg != seq_pkg::SW_ON)[*8])
    else $error("off-time cut short");
  a_term_hiz: assert property (on_st && !sleep_ctl_in |=>
    term_rail_hiz && !term_rail_en) else $error("term rail not high-Z");
  a_mode_frozen: assert property ($changed(mode_reg) |->
    st_reg == seq_pkg::ST_WAIT && $past(st_reg) != seq_pkg::ST_WAIT)
    else $error("mode changed outside start");
  a_prebias_off: assert property (st_reg == seq_pkg::ST_RAMP &&
    !reached_reg && !ov_done && !ov_lat_reg |=> !high_drive_out &&
    !low_drive_out) else $error("switching into pre-biased rail");

  c_pg_rise: cover property ($rose(power_good_out));
  c_uv_trip: cover property ($rose(uv_lat_reg));
  c_ov_trip: cover property ($rose(ov_lat_reg));
  c_trk_hand: cover property (track_dis_out ##1 nontrack_dis_out);
endmodule

/* File: tb/sleep_ctl_model.sv */
`timescale 1ns/1ps
// system power-state side: puts the requested state onto the two lines
module sleep_ctl_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [1:0] req,
  output logic            sleep_ctl_in,
  output logic            suspend_ctl_in
);
  // registered so both lines move together just after an edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleep_ctl_in   <= 1'b0;
      suspend_ctl_in <= 1'b0;
    end else begin
      sleep_ctl_in   <= req[1];
      suspend_ctl_in <= req[0];
    end
  end
endmodule

/* File: tb/ddr_rail_sequencer_protection_tb_top.sv */
`timescale 1ns/1ps
module ddr_rail_sequencer_protection_tb_top;
  localparam int W = 20;
  localparam int R = 512;
  logic        clock, rst_b, avs_read, avs_write, supply_ok_in, overtemp_in;
  logic        pg_cmp_in, ov_cmp_in, uv_cmp_in, dis_cmp_in, err_cmp_in;
  logic        valley_over_limit_in, zero_cross_in, sleep_ctl_in;
  logic        suspend_ctl_in, high_drive_out, low_drive_out, main_rail_en;
  logic        term_rail_en, term_rail_hiz, term_ref_en, track_dis_out;
  logic        nontrack_dis_out, power_good_out, power_good_oe;
  logic        light_load_pulse_skip, freq_670_out, avs_waitrequest;
  logic [1:0]  mode_in, req;
  logic [3:0]  avs_address, avs_byteenable, mon;
  logic [7:0]  rail_code_in, main_ref_code, term_ref_code;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          num_errors, comparisons, cyc, t0, n;

  assign mon = {main_rail_en, power_good_out, low_drive_out, high_drive_out};

  // free-running clock and a cycle count for interval checks
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  sleep_ctl_model i_host (.clock, .rst_b, .req, .sleep_ctl_in,
    .suspend_ctl_in);
  // short start counts keep the run brief
  ddr_rail_sequencer_protection #(.WAIT_CYC(W), .RAMP_CYC(R),
    .UV_EN_CYC(50)) i_dut (.clock, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .sleep_ctl_in, .suspend_ctl_in, .supply_ok_in,
    .overtemp_in, .mode_in, .rail_code_in, .pg_cmp_in, .ov_cmp_in,
    .uv_cmp_in, .dis_cmp_in, .err_cmp_in, .valley_over_limit_in,
    .zero_cross_in, .high_drive_out, .low_drive_out, .main_rail_en,
    .main_ref_code, .term_rail_en, .term_rail_hiz, .term_ref_en,
    .term_ref_code, .track_dis_out, .nontrack_dis_out, .power_good_out,
    .power_good_oe, .light_load_pulse_skip, .freq_670_out);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low; a hang is the watchdog's
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask

  // cycles until a watched output rises, capped at lim
  task rise(input int i, input int lim);
    n = 0;
    while (mon[i] !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask

  task wait_st(input logic [2:0] s);
    int k;
    k = 0;
    do begin
      bus(1'b0, seq_pkg::STATUS_OFS, 32'h0000_0000);
      k++;
    end while (q[2:0] !== s && k < 800);
    chk(q[2:0], s);
  endtask

  task t_regs;
    rd(seq_pkg::ONTIME_OFS, 32'hffff_ffff, 32'h0000_1319);
    bus(1'b1, seq_pkg::STATUS_OFS, 32'h0000_00ff);
    rd(seq_pkg::STATUS_OFS, 32'hffff_ffff, 32'h0000_0000);
    rd(4'hc, 32'hffff_ffff, 32'h0000_0000);
    bus(1'b1, seq_pkg::CTRL_OFS, 32'h0000_0001);
    rd(seq_pkg::CTRL_OFS, 32'hffff_ffff, 32'h0000_0001);
    bus(1'b1, seq_pkg::CTRL_OFS, 32'h0000_0000);
  endtask

  task t_start;
    chk(power_good_oe, 1'b1);
    @(posedge clock);
    supply_ok_in <= 1'b1;
    mode_in <= 2'h2;
    err_cmp_in <= 1'b1;
    req <= 2'b11;
    t0 = cyc;
    rise(3, 200);
    chk(n >= W && n <= W + 8, 1'b1);
    wait_st(seq_pkg::ST_RUN);
    chk(cyc - t0 >= W + R - 8 && cyc - t0 <= W + R + 16, 1'b1);
    chk({term_rail_en, term_ref_en, power_good_out}, 3'b110);
    chk({main_ref_code, term_ref_code}, 16'hffff);
    mode_in <= 2'h0;
    rd(seq_pkg::STATUS_OFS, 32'h0000_00c0, 32'h0000_0080);
    chk(freq_670_out, 1'b1);
    pg_cmp_in <= 1'b1;
    rise(2, 4000);
    chk(n >= seq_pkg::PG_DEB_CYC &&
      n <= seq_pkg::PG_DEB_CYC + 4, 1'b1);
    chk(power_good_oe, 1'b0);
    @(posedge clock);
    valley_over_limit_in <= 1'b1;
    repeat (60) @(posedge clock);
    rise(0, 40);
    chk(n, 40);
    @(posedge clock);
    valley_over_limit_in <= 1'b0;
    rise(0, 60);
    chk(n < 60, 1'b1);
    // no demand at zero cross: idle with both gates off
    @(posedge clock);
    err_cmp_in <= 1'b0;
    zero_cross_in <= 1'b1;
    repeat (60) @(negedge clock);
    chk({light_load_pulse_skip, low_drive_out}, 2'b10);
    @(posedge clock);
    err_cmp_in <= 1'b1;
    zero_cross_in <= 1'b0;
  endtask

  // undervoltage: delay, latch, soft-stop, cleared by supply-ok toggle
  task t_uv;
    @(posedge clock);
    uv_cmp_in <= 1'b1;
    repeat (700) @(posedge clock);
    rd(seq_pkg::STATUS_OFS, 32'h0000_0008, 32'h0000_0000);
    repeat (110) @(posedge clock);
    uv_cmp_in <= 1'b0;
    repeat (2) @(negedge clock);
    chk({high_drive_out, low_drive_out, power_good_out}, 3'b000);
    chk(main_ref_code < 8'hff, 1'b1);
    rd(seq_pkg::STATUS_OFS, 32'h0000_0008, 32'h0000_0008);
    supply_ok_in <= 1'b0;
    repeat (3) @(posedge clock);
    supply_ok_in <= 1'b1;
    mode_in <= 2'h3;
    wait_st(seq_pkg::ST_RUN);
    rd(seq_pkg::STATUS_OFS, 32'h0000_00c8, 32'h0000_00c0);
    chk(freq_670_out, 1'b0);
    rise(2, 4000);
    chk(n < 4000, 1'b1);
  endtask

  // overvoltage drop, latch, and clearing by a supply-ok toggle
  task t_ov;
    @(posedge clock);
    ov_cmp_in <= 1'b1;
    repeat (2) @(negedge clock);
    chk(power_good_out, 1'b0);
    repeat (80) @(posedge clock);
    rd(seq_pkg::STATUS_OFS, 32'h0000_0010, 32'h0000_0010);
    ov_cmp_in <= 1'b0;
    rise(0, 60);
    chk(n, 60);
    chk(power_good_out, 1'b0);
    @(posedge clock);
    supply_ok_in <= 1'b0;
    repeat (3) @(posedge clock);
    supply_ok_in <= 1'b1;
    wait_st(seq_pkg::ST_RAMP);
    rd(seq_pkg::STATUS_OFS, 32'h0000_0018, 32'h0000_0000);
  endtask

  task t_states;
    @(posedge clock);
    overtemp_in <= 1'b1;
    mode_in <= 2'h1;
    repeat (4) @(negedge clock);
    chk({main_rail_en, term_rail_en, term_ref_en}, 3'b000);
    @(posedge clock);
    overtemp_in <= 1'b0;
    wait_st(seq_pkg::ST_RAMP);
    chk(freq_670_out, 1'b1);
    @(posedge clock);
    req <= 2'b01;
    repeat (4) @(negedge clock);
    chk({term_rail_hiz, term_rail_en, term_ref_en,
      main_rail_en}, 4'hb);
    @(posedge clock);
    req <= 2'b00;
    repeat (4) @(negedge clock);
    chk({main_rail_en, term_rail_en, term_ref_en, power_good_oe,
      track_dis_out, nontrack_dis_out}, 32'h0000_0006);
    @(posedge clock);
    dis_cmp_in <= 1'b1;
    repeat (3) @(negedge clock);
    chk({track_dis_out, nontrack_dis_out}, 2'b01);
    bus(1'b1, seq_pkg::CTRL_OFS, 32'h0000_0001);
    repeat (3) @(negedge clock);
    chk({track_dis_out, nontrack_dis_out}, 2'b00);
  endtask

  task end_sim;
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog: the sequence needs well under 20000 cycles
  initial begin
    #400_000;
    num_errors++;
    end_sim;
  end

  initial begin
    {avs_read, avs_write, supply_ok_in, overtemp_in, pg_cmp_in} = '0;
    {ov_cmp_in, uv_cmp_in, dis_cmp_in, err_cmp_in} = '0;
    {valley_over_limit_in, zero_cross_in, mode_in, req} = '0;
    {avs_address, rail_code_in, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    rst_b = 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    t_regs;
    t_start;
    t_uv;
    t_ov;
    t_states;
    end_sim;
  end
endmodule
